// ### design/pei_pkg.sv
// Package for the processor error and initialization sideband block.
// Assumes a single 10 MHz clock and synchronous active-low reset in both ends.
package pei_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam logic [3:0]  STALL_CYCLES   = 4'h3;
  localparam logic [1:0]  SYNC_ZERO      = 2'h0;
  localparam logic [1:0]  SYNC_ONE       = 2'h3;
  localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'hFFFFFFF0;
  localparam logic [31:0] REG_ZERO       = 32'h00000000;
  localparam logic [3:0]  STALL_ZERO     = 4'h0;

  typedef enum logic [1:0]
  {
    PEI_RUN   = 2'h0,
    PEI_INIT  = 2'h1,
    PEI_BIST  = 2'h3
  } pei_core_state_t;
endpackage : pei_pkg

// ### design/pei_if.sv
// Interface joining the processor end and the core logic end.
// Resolves the open-drain snoop lines from the enables inside the interface.
`timescale 1ns/100ps
interface pei_if;
  logic snoop_hit_n;
  logic snoop_modified_n;
  logic proc_hit_out_n;
  logic proc_hit_oe_n;
  logic proc_mod_out_n;
  logic proc_mod_oe_n;
  logic cl_hit_out_n;
  logic cl_hit_oe_n;
  logic cl_mod_out_n;
  logic cl_mod_oe_n;
  logic internal_fault_n;
  logic ignore_numeric_fault_n;
  logic init_n;
  logic bus_reinit_n;
  logic target_ready_n;
  logic stop_clock_request_n;
  logic fp_fault_or_break_event_n;
  logic halt_special_transaction;

  // Wired-OR of active-low open-drain drivers
  assign snoop_hit_n      = (proc_hit_oe_n | proc_hit_out_n) & (cl_hit_oe_n | cl_hit_out_n);
  assign snoop_modified_n = (proc_mod_oe_n | proc_mod_out_n) & (cl_mod_oe_n | cl_mod_out_n);

  modport proc
  (
    input  snoop_hit_n, snoop_modified_n, ignore_numeric_fault_n, init_n, bus_reinit_n,
           target_ready_n, stop_clock_request_n,
    output proc_hit_out_n, proc_hit_oe_n, proc_mod_out_n, proc_mod_oe_n, internal_fault_n,
           fp_fault_or_break_event_n, halt_special_transaction
  );
  modport core
  (
    input  snoop_hit_n, snoop_modified_n, internal_fault_n, fp_fault_or_break_event_n,
           halt_special_transaction,
    output cl_hit_out_n, cl_hit_oe_n, cl_mod_out_n, cl_mod_oe_n, ignore_numeric_fault_n,
           init_n, bus_reinit_n, target_ready_n, stop_clock_request_n
  );
endinterface : pei_if

// ### design/pei_sync.sv
// Two-flop synchronizer for one asynchronous active-low level.
// Assumes reset value is the inactive (high) level.
`timescale 1ns/100ps
module pei_sync
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [1:0] sync_reg;
  logic [1:0] sync_next;

  always_comb
  begin
    sync_next = {sync_reg[0], async_in};
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sync_reg <= pei_pkg::SYNC_ONE;
    else
      sync_reg <= sync_next;
  end

  assign sync_out = sync_reg[1];
endmodule : pei_sync

// ### design/pei_proc.sv
// Processor end: internal error, numeric-error gating, init handling, snoop stall.
// Assumes the core logic keeps async inputs stable around target_ready_n for I/O writes.
// Overview of operation
// RULE1: Request snoop stall with hit and modified together
// RULE2: Re-assert both together to extend stall
// RULE3: Drive internal fault on internal error
// RULE4: Hold fault until reset, bus reinit, init
// RULE5: Issue halt transaction with internal fault
// RULE6: Ignore numeric error while ignore input active
// RULE7: Raise exception on pending error otherwise
// RULE8: Native mode bit disables ignore input
// RULE9: Ignore input valid at target ready
// RULE10: Init resets integer registers, keeps cache, fp
// RULE11: Restart at configured reset vector after init
// RULE12: Keep servicing snoops during init
// RULE13: Init input valid at target ready
// RULE14: Init low at reset release starts self-test
// RULE15: Fp fault pin shows break under stop clock
// RULE16: All sideband signals are active low; halt_special_transaction is driven active high
`timescale 1ns/100ps
module pei_proc
(
  input  wire logic   clk,
  input  wire logic   reset_n,
  pei_if.proc         bus,
  input  wire logic   internal_error,
  input  wire logic   snoop_request,
  input  wire logic   snoop_slow,
  input  wire logic   fp_error_event,
  input  wire logic   fp_noncontrol_exec,
  input  wire logic   break_event,
  input  wire logic   native_numeric_fault_mode,
  input  wire logic [31:0] reset_vector,
  output logic        fp_exception,
  output logic        snoop_done,
  output logic        bist_run,
  output logic [31:0] fetch_address,
  output logic [31:0] integer_reg0,
  output logic        init_active
);
  logic ignore_s;
  logic init_s;
  logic reinit_s;
  logic stopclk_s;
  logic hit_s;
  logic mod_s;

  pei_sync u_sync_ign  (.clk(clk), .reset_n(reset_n), .async_in(bus.ignore_numeric_fault_n), .sync_out(ignore_s));
  pei_sync u_sync_init (.clk(clk), .reset_n(reset_n), .async_in(bus.init_n),                 .sync_out(init_s));
  pei_sync u_sync_bri  (.clk(clk), .reset_n(reset_n), .async_in(bus.bus_reinit_n),           .sync_out(reinit_s));
  pei_sync u_sync_stp  (.clk(clk), .reset_n(reset_n), .async_in(bus.stop_clock_request_n),   .sync_out(stopclk_s));
  pei_sync u_sync_hit  (.clk(clk), .reset_n(reset_n), .async_in(bus.snoop_hit_n),            .sync_out(hit_s));
  pei_sync u_sync_mod  (.clk(clk), .reset_n(reset_n), .async_in(bus.snoop_modified_n),       .sync_out(mod_s));

  pei_pkg::pei_core_state_t state_reg;
  pei_pkg::pei_core_state_t state_next;
  logic        fault_reg,    fault_next;
  logic        halt_reg,     halt_next;
  logic        fp_pend_reg,  fp_pend_next;
  logic        fp_exc_reg,   fp_exc_next;
  logic        brk_reg,      brk_next;
  logic        fpo_reg,      fpo_next;
  logic [31:0] ireg_reg,     ireg_next;
  logic [31:0] fetch_reg,    fetch_next;
  logic [2:0]  first_reg,    first_next;
  logic [3:0]  stall_reg,    stall_next;
  logic        sdone_reg,    sdone_next;
  logic        stall_drv_reg, stall_drv_next;

  always_comb
  begin
    state_next     = state_reg;
    fault_next     = fault_reg;
    halt_next      = 1'b0;
    fp_pend_next   = fp_pend_reg;
    fp_exc_next    = 1'b0;
    brk_next       = brk_reg;
    fpo_next       = fpo_reg;
    ireg_next      = ireg_reg;
    fetch_next     = fetch_reg;
    first_next     = {first_reg[1:0], 1'b0};
    stall_next     = stall_reg;
    sdone_next     = 1'b0;
    stall_drv_next = 1'b0;

    // Strap judged on the third edge after release, once the synchronizer holds the pin
    if (|first_reg)
    begin
      if (first_reg[2] && !first_reg[1])
      begin
        if (!init_s)
          state_next = pei_pkg::PEI_BIST; // RULE14
        else
          state_next = pei_pkg::PEI_RUN;
      end
    end
    else
    begin
      unique case (state_reg)
        pei_pkg::PEI_RUN:
        begin
          if (!init_s)
            state_next = pei_pkg::PEI_INIT;
        end
        pei_pkg::PEI_INIT:
        begin
          ireg_next = pei_pkg::REG_ZERO; // RULE10
          if (init_s)
          begin
            state_next = pei_pkg::PEI_RUN;
            fetch_next = reset_vector; // RULE11
          end
        end
        pei_pkg::PEI_BIST:
        begin
          state_next = pei_pkg::PEI_RUN;
          fetch_next = reset_vector;
        end
        default:
          state_next = pei_pkg::PEI_RUN;
      endcase
    end
    if (state_reg == pei_pkg::PEI_RUN && fp_noncontrol_exec)
      ireg_next = ireg_reg + 32'h00000001;

    // Clear sources dominate a new error since all three reset the core
    if (!init_s || !reinit_s)
      fault_next = 1'b0; // RULE4
    else if (internal_error)
    begin
      fault_next = 1'b1; // RULE3
      halt_next  = !fault_reg; // RULE5
    end

    // Floating-point error pending until an exception consumes it; set wins over clear
    if (fp_noncontrol_exec && fp_pend_reg && (native_numeric_fault_mode || ignore_s))
    begin
      fp_exc_next  = 1'b1; // RULE7 RULE8
      fp_pend_next = fp_error_event;
    end
    else if (fp_error_event)
      fp_pend_next = 1'b1; // RULE6

    if (stopclk_s)
      brk_next = 1'b0;
    else if (break_event)
      brk_next = 1'b1;
    fpo_next = !(stopclk_s ? fp_pend_reg : brk_reg); // RULE15 RULE16

    // Snoops are serviced in every state, including init
    if (snoop_request && stall_reg == pei_pkg::STALL_ZERO)
      stall_next = snoop_slow ? pei_pkg::STALL_CYCLES : 4'h1; // RULE12
    // A joint stall from the far agent holds completion back; our own drive is not yet visible here
    else if (stall_reg == 4'h1 && !hit_s && !mod_s)
      stall_next = stall_reg; // RULE2
    else if (stall_reg != pei_pkg::STALL_ZERO)
    begin
      stall_next     = stall_reg - 4'h1;
      stall_drv_next = (stall_reg != 4'h1); // RULE1 RULE2
      sdone_next     = (stall_reg == 4'h1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg     <= pei_pkg::PEI_INIT;
      fault_reg     <= 1'b0;
      halt_reg      <= 1'b0;
      fp_pend_reg   <= 1'b0;
      fp_exc_reg    <= 1'b0;
      brk_reg       <= 1'b0;
      fpo_reg       <= 1'b1;
      ireg_reg      <= pei_pkg::REG_ZERO;
      fetch_reg     <= pei_pkg::RESET_VECTOR_DEFAULT;
      first_reg     <= {3{1'b1}};
      stall_reg     <= pei_pkg::STALL_ZERO;
      sdone_reg     <= 1'b0;
      stall_drv_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      fault_reg     <= fault_next;
      halt_reg      <= halt_next;
      fp_pend_reg   <= fp_pend_next;
      fp_exc_reg    <= fp_exc_next;
      brk_reg       <= brk_next;
      fpo_reg       <= fpo_next;
      ireg_reg      <= ireg_next;
      fetch_reg     <= fetch_next;
      first_reg     <= first_next;
      stall_reg     <= stall_next;
      sdone_reg     <= sdone_next;
      stall_drv_reg <= stall_drv_next;
    end
  end

  assign bus.internal_fault_n          = !fault_reg; // RULE16
  assign bus.halt_special_transaction  = halt_reg;
  assign bus.fp_fault_or_break_event_n = fpo_reg;
  assign bus.proc_hit_out_n            = 1'b0;
  assign bus.proc_mod_out_n            = 1'b0;
  assign bus.proc_hit_oe_n             = !stall_drv_reg; // RULE1
  assign bus.proc_mod_oe_n             = !stall_drv_reg; // RULE1
  assign fp_exception                  = fp_exc_reg;
  assign snoop_done                    = sdone_reg;
  assign bist_run                      = (state_reg == pei_pkg::PEI_BIST);
  assign fetch_address                 = fetch_reg;
  assign integer_reg0                  = ireg_reg;
  assign init_active                   = (state_reg == pei_pkg::PEI_INIT);
endmodule : pei_proc

// ### design/pei_core.sv
// Core logic end: drives init, ignore, reinit, stop clock; watches fault and stalls.
// Assumes user-side requests are synchronous to clk.
`timescale 1ns/100ps
module pei_core
(
  input  wire logic clk,
  input  wire logic reset_n,
  pei_if.core       bus,
  input  wire logic init_req,
  input  wire logic ignore_req,
  input  wire logic reinit_req,
  input  wire logic stop_clock_req,
  input  wire logic io_write_ready,
  input  wire logic stall_req,
  output logic      nmi_out,
  output logic      fault_seen,
  output logic      stall_seen,
  output logic      break_or_fp_seen
);
  logic hit_s;
  logic mod_s;
  logic flt_s;
  logic fpo_s;

  pei_sync u_sync_hit (.clk(clk), .reset_n(reset_n), .async_in(bus.snoop_hit_n),               .sync_out(hit_s));
  pei_sync u_sync_mod (.clk(clk), .reset_n(reset_n), .async_in(bus.snoop_modified_n),          .sync_out(mod_s));
  pei_sync u_sync_flt (.clk(clk), .reset_n(reset_n), .async_in(bus.internal_fault_n),          .sync_out(flt_s));
  pei_sync u_sync_fpo (.clk(clk), .reset_n(reset_n), .async_in(bus.fp_fault_or_break_event_n), .sync_out(fpo_s));

  logic init_reg, init_next;
  logic ign_reg,  ign_next;
  logic bri_reg,  bri_next;
  logic stp_reg,  stp_next;
  logic target_ready_n_reg, target_ready_n_next;
  logic stl_reg,  stl_next;
  logic nmi_reg,  nmi_next;

  always_comb
  begin
    // Init and ignore levels change only with the target-ready pulse so the processor sees them settled
    init_next = init_reg;
    ign_next  = ign_reg;
    if (io_write_ready)
    begin
      init_next = init_req; // RULE13
      ign_next  = ignore_req; // RULE9
    end
    bri_next  = reinit_req;
    stp_next  = stop_clock_req;
    target_ready_n_next = io_write_ready;
    stl_next  = stall_req; // RULE2
    nmi_next  = bus.halt_special_transaction; // RULE5
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      // Strap held through reset so the processor sees it at release
      init_reg <= init_req; // RULE14
      ign_reg  <= 1'b0;
      bri_reg  <= 1'b0;
      stp_reg  <= 1'b0;
      target_ready_n_reg <= 1'b0;
      stl_reg  <= 1'b0;
      nmi_reg  <= 1'b0;
    end
    else
    begin
      init_reg <= init_next;
      ign_reg  <= ign_next;
      bri_reg  <= bri_next;
      stp_reg  <= stp_next;
      target_ready_n_reg <= target_ready_n_next;
      stl_reg  <= stl_next;
      nmi_reg  <= nmi_next;
    end
  end

  assign bus.init_n                 = !init_reg; // RULE16
  assign bus.ignore_numeric_fault_n = !ign_reg;
  assign bus.bus_reinit_n           = !bri_reg;
  assign bus.stop_clock_request_n   = !stp_reg;
  assign bus.target_ready_n         = !target_ready_n_reg;
  assign bus.cl_hit_out_n           = 1'b0;
  assign bus.cl_mod_out_n           = 1'b0;
  assign bus.cl_hit_oe_n            = !stl_reg; // RULE1
  assign bus.cl_mod_oe_n            = !stl_reg; // RULE1
  assign nmi_out                    = nmi_reg;
  assign fault_seen                 = !flt_s;
  assign stall_seen                 = !hit_s && !mod_s; // RULE2
  assign break_or_fp_seen           = !fpo_s;
endmodule : pei_core

// ### testbench/pei_sva.sv
// Checker on the sideband lines between the processor end and the core end.
// Assumes it sits beside the interface instance in the bench.
`timescale 1ns/100ps
module pei_sva
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic proc_hit_oe_n,
  input wire logic proc_mod_oe_n,
  input wire logic proc_hit_out_n,
  input wire logic cl_hit_oe_n,
  input wire logic cl_mod_oe_n,
  input wire logic snoop_hit_n,
  input wire logic snoop_modified_n,
  input wire logic internal_fault_n,
  input wire logic halt_special_transaction,
  input wire logic init_n,
  input wire logic bus_reinit_n
);
  logic [7:0] clr_hist_reg;
  logic [7:0] clr_hist_next;
  logic       clr_now;
  // Clears pass a synchronizer, so the history is kept wide on purpose
  assign clr_now = ~init_n | ~bus_reinit_n;
  always_comb clr_hist_next = reset_n ? {clr_hist_reg[6:0], clr_now} : 8'hFF;
  always_ff @(posedge clk) clr_hist_reg <= clr_hist_next;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_stall_on;
    !proc_hit_oe_n && !proc_mod_oe_n;
  endsequence
  sequence s_stall_run;
    s_stall_on [*2] ##1 (proc_hit_oe_n && proc_mod_oe_n);
  endsequence
  sequence s_halt;
    halt_special_transaction ##1 !halt_special_transaction;
  endsequence

  AST_STALL_TOGETHER: assert property (proc_hit_oe_n == proc_mod_oe_n)
    else $error("processor drove one snoop line alone");
  AST_CORE_TOGETHER: assert property (cl_hit_oe_n == cl_mod_oe_n)
    else $error("core drove one snoop line alone");
  AST_STALL_LEN: assert property ($fell(proc_hit_oe_n) |-> s_stall_run)
    else $error("snoop stall length wrong");
  AST_DRIVE_LOW: assert property (!proc_hit_oe_n |-> !proc_hit_out_n && !snoop_hit_n && !snoop_modified_n)
    else $error("stall not seen low on the wire");
  AST_WIRE_IDLE: assert property (proc_hit_oe_n && cl_hit_oe_n |-> snoop_hit_n)
    else $error("snoop line low with no driver");
  AST_HALT_WITH_FAULT: assert property ($fell(internal_fault_n) |-> s_halt)
    else $error("fault raised without one halt pulse");
  AST_FAULT_RISE: assert property ($rose(internal_fault_n) |-> clr_now || (|clr_hist_reg))
    else $error("fault released without a clear");
  AST_FAULT_HOLD: assert property (!internal_fault_n && !clr_now && clr_hist_reg == 8'h00 |=> !internal_fault_n)
    else $error("fault dropped early");
endmodule : pei_sva

// ### testbench/pei_tb_top.sv
// Bench joining both ends through the interface, queue-based scoreboard.
// Assumes a 10 MHz clock and synchronous active-low reset.
`timescale 1ns/100ps
module pei_tb_top;
  logic        clk, reset_n, internal_error, snoop_request, snoop_slow, fp_error_event;
  logic        fp_noncontrol_exec, break_event, native_mode, fp_exception, snoop_done;
  logic        bist_run, init_active, init_req, ignore_req, reinit_req, stop_clock_req;
  logic        io_write_ready, stall_req, nmi_out, fault_seen, stall_seen, break_or_fp_seen;
  logic [31:0] reset_vector, fetch_address, integer_reg0;
  logic [1:0]  exp_q[$];
  int          miscompares, checked, k, n;

  pei_if bus ();
  pei_proc i_pei_proc (.clk(clk), .reset_n(reset_n), .bus(bus), .internal_error(internal_error),
    .snoop_request(snoop_request), .snoop_slow(snoop_slow), .fp_error_event(fp_error_event),
    .fp_noncontrol_exec(fp_noncontrol_exec), .break_event(break_event),
    .native_numeric_fault_mode(native_mode), .reset_vector(reset_vector), .fp_exception(fp_exception),
    .snoop_done(snoop_done), .bist_run(bist_run), .fetch_address(fetch_address),
    .integer_reg0(integer_reg0), .init_active(init_active));
  pei_core i_pei_core (.clk(clk), .reset_n(reset_n), .bus(bus), .init_req(init_req),
    .ignore_req(ignore_req), .reinit_req(reinit_req), .stop_clock_req(stop_clock_req),
    .io_write_ready(io_write_ready), .stall_req(stall_req), .nmi_out(nmi_out), .fault_seen(fault_seen),
    .stall_seen(stall_seen), .break_or_fp_seen(break_or_fp_seen));
  pei_sva i_pei_sva (.clk(clk), .reset_n(reset_n), .proc_hit_oe_n(bus.proc_hit_oe_n),
    .proc_mod_oe_n(bus.proc_mod_oe_n), .proc_hit_out_n(bus.proc_hit_out_n), .cl_hit_oe_n(bus.cl_hit_oe_n),
    .cl_mod_oe_n(bus.cl_mod_oe_n), .snoop_hit_n(bus.snoop_hit_n), .snoop_modified_n(bus.snoop_modified_n),
    .internal_fault_n(bus.internal_fault_n), .halt_special_transaction(bus.halt_special_transaction),
    .init_n(bus.init_n), .bus_reinit_n(bus.bus_reinit_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  localparam int P_ERR = 0;
  localparam int P_SNP = 1;
  localparam int P_FPE = 2;
  localparam int P_EXE = 3;
  localparam int P_BRK = 4;
  localparam int P_BRI = 5;
  localparam int P_IOW = 6;

  // Each strobe is written by name, so every input has a visible driver
  task automatic drive(input int sel, input logic v);
    case (sel)
      P_ERR: internal_error = v;
      P_SNP: snoop_request = v;
      P_FPE: fp_error_event = v;
      P_EXE: fp_noncontrol_exec = v;
      P_BRK: break_event = v;
      P_BRI: reinit_req = v;
      default: io_write_ready = v;
    endcase
  endtask : drive

  task automatic pulse(input int sel);
    drive(sel, 1'b1);
    @(negedge clk);
    drive(sel, 1'b0);
  endtask : pulse

  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask : idle

  // Codes: 1 exception, 2 snoop done, 3 nmi; an unexpected event meets code 0
  task automatic take(input logic [1:0] code);
    chk(code, (exp_q.size() == 0) ? 2'h0 : exp_q.pop_front());
  endtask : take

  always @(negedge clk)
    if (reset_n === 1'b1)
    begin
      if (fp_exception === 1'b1) take(2'h1);
      if (snoop_done === 1'b1) take(2'h2);
      if (nmi_out === 1'b1) take(2'h3);
    end

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    {reset_n, internal_error, snoop_request, snoop_slow, fp_error_event, fp_noncontrol_exec} = 6'h00;
    {break_event, native_mode, init_req, ignore_req, reinit_req, stop_clock_req} = 6'h00;
    {io_write_ready, stall_req} = 2'h0;
    k = $urandom(87058);
    reset_vector = $urandom;
    n = 1 + ($urandom % 4);
    idle(4);
    reset_n = 1'b1;
    idle(3);
    chk(bist_run, 1'b0);
    // One strobe held n cycles: one increment per cycle, no same-step re-raise
    fp_noncontrol_exec = 1'b1;
    idle(n);
    fp_noncontrol_exec = 1'b0;
    pulse(P_FPE);
    idle(2);
    chk(integer_reg0, n);
    init_req = 1'b1;
    pulse(P_IOW);
    for (k = 0; k < 10 && init_active !== 1'b1; k++) @(negedge clk);
    chk(init_active, 1'b1);
    idle(1);
    chk(integer_reg0, 32'h0);
    exp_q.push_back(2'h2);
    pulse(P_SNP);
    idle(4);
    init_req = 1'b0;
    pulse(P_IOW);
    for (k = 0; k < 10 && init_active !== 1'b0; k++) @(negedge clk);
    chk(init_active, 1'b0);
    idle(1);
    chk(fetch_address, reset_vector);
    exp_q.push_back(2'h1);
    pulse(P_EXE);
    idle(3);
    ignore_req = 1'b1;
    pulse(P_IOW);
    idle(6);
    pulse(P_FPE);
    pulse(P_EXE);
    idle(3);
    chk(bus.fp_fault_or_break_event_n, 1'b0);
    native_mode = 1'b1;
    exp_q.push_back(2'h1);
    pulse(P_EXE);
    idle(3);
    {native_mode, ignore_req} = 2'h0;
    pulse(P_IOW);
    stop_clock_req = 1'b1;
    idle(4);
    pulse(P_BRK);
    idle(5);
    chk(bus.fp_fault_or_break_event_n, 1'b0);
    chk(break_or_fp_seen, 1'b1);
    stop_clock_req = 1'b0;
    idle(6);
    chk(bus.fp_fault_or_break_event_n, 1'b1);
    exp_q.push_back(2'h3);
    pulse(P_ERR);
    chk(bus.internal_fault_n, 1'b0);
    idle(6);
    chk(bus.internal_fault_n, 1'b0);
    chk(fault_seen, 1'b1);
    pulse(P_BRI);
    idle(6);
    chk(bus.internal_fault_n, 1'b1);
    exp_q.push_back(2'h3);
    pulse(P_ERR);
    init_req = 1'b1;
    pulse(P_IOW);
    idle(6);
    chk(bus.internal_fault_n, 1'b1);
    init_req = 1'b0;
    pulse(P_IOW);
    idle(6);
    // Slow snoop: the stall reaches the far end on the same edge that completes the snoop
    snoop_slow = 1'b1;
    exp_q.push_back(2'h2);
    pulse(P_SNP);
    for (k = 0; k < 10 && stall_seen !== 1'b1; k++) @(negedge clk);
    chk(stall_seen, 1'b1);
    snoop_slow = 1'b0;
    idle(4);
    // Far-end stall: a snoop taken now must not finish before the lines are released
    stall_req = 1'b1;
    idle(3);
    chk({bus.snoop_hit_n, bus.snoop_modified_n}, 2'h0);
    pulse(P_SNP);
    idle(4);
    exp_q.push_back(2'h2);
    stall_req = 1'b0;
    idle(6);
    chk(bus.snoop_hit_n, 1'b1);
    // Second reset with the strap held low selects the self-test
    init_req = 1'b1;
    reset_n = 1'b0;
    idle(4);
    reset_n = 1'b1;
    for (k = 0; k < 10 && bist_run !== 1'b1; k++) @(negedge clk);
    chk(bist_run, 1'b1);
    idle(1);
    chk(fetch_address, reset_vector);
    init_req = 1'b0;
    pulse(P_IOW);
    for (k = 0; k < 10 && init_active !== 1'b0; k++) @(negedge clk);
    chk(init_active, 1'b0);
    chk(32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule : pei_tb_top
